// [design/rpc_port_config.sv]
`timescale 1ns/1ps
`include "rpc_defines.svh"
module rpc_port_config #(
    parameter int unsigned BLINK_FAST_HALF = `RPC_BLINK_FAST_MS * `RPC_CLK_KHZ / 2,
    parameter int unsigned BLINK_SLOW_HALF = `RPC_BLINK_SLOW_MS * `RPC_CLK_KHZ / 2
) (
    input wire logic clk_in,                                  // 25 MHz clock
    input wire logic sys_rst_in,                              // Synchronous reset, high
    input wire logic serial_cmd_in,                           // Serial input level, strap
    input wire logic is_secondary_in,                         // High: secondary device
    input wire rpc_pkg::rpc_cmd_t cmd_in,                     // Decoded command byte
    input wire logic [3:0] link_raw_pass_in,                  // Link test result per port
    input wire logic [1:0] blink_rate_in,                     // Last issued blink rate
    input wire logic [2:0] led_display_config_inputs,         // LED content select
    input wire rpc_pkg::rpc_led_attr_t led_attr_in,           // Candidate LED attributes
    output logic aui_enable_out,                              // AUI port enabled
    output logic aui_part_idle_out,                           // AUI partition to idle
    output rpc_pkg::rpc_tp_cfg_t tp_cfg_out,                  // Twisted-pair port settings
    output logic [3:0] tp_part_idle_out,                      // Port partition to idle
    output logic [3:0] link_pass_out,                         // Reported link status
    output logic [5:0] led_override_out,                      // LEDs under override
    output logic [5:0] led_n_out                              // LED drivers, low lit
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic port_hit(input logic [2:0] fld, input logic sec,
                                      input int idx);
        port_hit = (fld[2] == ~sec) && (fld[1:0] == idx[1:0]);
    endfunction : port_hit

    function automatic logic led_hit(input logic [3:0] sel, input logic sec,
                                     input int idx);
        logic tp;
        tp = (idx < `RPC_LED_AUI);
        case (sel)
            `RPC_SEL_AUI_PRI: led_hit = (idx == `RPC_LED_AUI) && !sec;
            `RPC_SEL_AUI_SEC: led_hit = (idx == `RPC_LED_AUI) && sec;
            `RPC_SEL_AUI_ALL: led_hit = (idx == `RPC_LED_AUI);
            `RPC_SEL_TP_ALL: led_hit = tp;
            `RPC_SEL_PORT_ALL: led_hit = tp || (idx == `RPC_LED_AUI);
            `RPC_SEL_GLB_PRI: led_hit = (idx == `RPC_LED_GLB) && !sec;
            `RPC_SEL_GLB_SEC: led_hit = (idx == `RPC_LED_GLB) && sec;
            `RPC_SEL_GLB_ALL: led_hit = (idx == `RPC_LED_GLB);
            default: led_hit = tp && port_hit(sel[2:0], sec, idx);
        endcase
    endfunction : led_hit

    // ****************************************
    // Port configuration state
    // ****************************************
    logic aui_en_q, aui_en_d, aui_idle_q, aui_idle_d;
    logic [3:0] tp_en_q, tp_en_d, lt_q, lt_d, lp_q, lp_d, pol_q, pol_d, ext_q, ext_d;
    logic [3:0] tp_idle_q, tp_idle_d, pass_q, pass_d;
    logic [4:0] op;

    assign op = cmd_in.code[7:3];

    always_comb begin
        aui_en_d = aui_en_q;
        aui_idle_d = 1'b0;
        tp_en_d = tp_en_q;
        tp_idle_d = 4'h0;
        lt_d = lt_q;
        lp_d = lp_q;
        pol_d = pol_q;
        ext_d = ext_q;
        if (cmd_in.valid) begin
            if ((cmd_in.code == `RPC_CMD_AUI_DIS_SEC && is_secondary_in) ||
                (cmd_in.code == `RPC_CMD_AUI_DIS_PRI && !is_secondary_in)) begin
                aui_en_d = 1'b0;
                aui_idle_d = 1'b1;
            end
            if ((cmd_in.code == `RPC_CMD_AUI_EN_SEC && is_secondary_in) ||
                (cmd_in.code == `RPC_CMD_AUI_EN_PRI && !is_secondary_in)) begin
                aui_en_d = 1'b1;
            end
            for (int i = 0; i < 4; i++) begin
                if (port_hit(cmd_in.code[2:0], is_secondary_in, i)) begin
                    case (op)
                        `RPC_OP_TP_DIS: begin
                            tp_en_d[i] = 1'b0;
                            tp_idle_d[i] = 1'b1;
                        end
                        `RPC_OP_TP_EN: tp_en_d[i] = 1'b1;
                        `RPC_OP_LT_DIS: lt_d[i] = 1'b0;
                        `RPC_OP_LT_EN: lt_d[i] = 1'b1;
                        `RPC_OP_LP_DIS: lp_d[i] = 1'b0;
                        `RPC_OP_LP_EN: lp_d[i] = 1'b1;
                        `RPC_OP_POL_DIS: pol_d[i] = 1'b0;
                        `RPC_OP_POL_EN: pol_d[i] = 1'b1;
                        `RPC_OP_EXT_DIS: ext_d[i] = 1'b0;
                        `RPC_OP_EXT_EN: ext_d[i] = 1'b1;
                        default: ;
                    endcase
                end
            end
        end
        pass_d = link_raw_pass_in | ~lt_q;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aui_en_q <= 1'b1;
            aui_idle_q <= 1'b0;
            tp_en_q <= `RPC_RST_TP_EN;
            tp_idle_q <= 4'h0;
            lt_q <= `RPC_RST_LT_EN;
            lp_q <= `RPC_RST_LP_EN;
            pol_q <= {4{~serial_cmd_in}};
            ext_q <= `RPC_RST_EXT;
            pass_q <= 4'h0;
        end else begin
            aui_en_q <= aui_en_d;
            aui_idle_q <= aui_idle_d;
            tp_en_q <= tp_en_d;
            tp_idle_q <= tp_idle_d;
            lt_q <= lt_d;
            lp_q <= lp_d;
            pol_q <= pol_d;
            ext_q <= ext_d;
            pass_q <= pass_d;
        end
    end

    // ****************************************
    // LED override and blink
    // ****************************************
    logic [5:0] ovr_q, ovr_d, led_q, led_d;
    logic [24:0] blink_cnt_q, blink_cnt_d, half;
    logic phase_q, phase_d, lit_ovr;

    always_comb begin
        ovr_d = ovr_q;
        if (cmd_in.valid) begin
            for (int i = 0; i < 6; i++) begin
                if (led_hit(cmd_in.code[3:0], is_secondary_in, i)) begin
                    if (cmd_in.code[7:4] == `RPC_OP_LED_OFF) begin
                        ovr_d[i] = 1'b0;
                    end
                    if (cmd_in.code[7:4] == `RPC_OP_LED_ON) begin
                        ovr_d[i] = 1'b1;
                    end
                end
            end
        end
        // Rate changes apply the new half period to the running count at once, without a restart
        half = (blink_rate_in == `RPC_BLINK_SLOW) ? 25'(BLINK_SLOW_HALF - 1)
                                                  : 25'(BLINK_FAST_HALF - 1);
        if (blink_cnt_q >= half) begin
            blink_cnt_d = 25'h0;
            phase_d = ~phase_q;
        end else begin
            blink_cnt_d = blink_cnt_q + 25'h1;
            phase_d = phase_q;
        end
        case (blink_rate_in)
            `RPC_BLINK_OFF: lit_ovr = 1'b0;
            `RPC_BLINK_SOLID: lit_ovr = 1'b1;
            default: lit_ovr = phase_q;
        endcase
        for (int i = 0; i < 6; i++) begin
            led_d[i] = ovr_q[i] ? ~lit_ovr : ~led_attr_in[i][led_display_config_inputs];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ovr_q <= `RPC_RST_OVR;
            led_q <= 6'h3F;
            blink_cnt_q <= 25'h0;
            phase_q <= 1'b0;
        end else begin
            ovr_q <= ovr_d;
            led_q <= led_d;
            blink_cnt_q <= blink_cnt_d;
            phase_q <= phase_d;
        end
    end

    assign aui_enable_out = aui_en_q;
    assign aui_part_idle_out = aui_idle_q;
    assign tp_cfg_out = '{enable: tp_en_q, link_test_en: lt_q, link_pulse_en: lp_q,
                          pol_auto_en: pol_q, ext_dist: ext_q};
    assign tp_part_idle_out = tp_idle_q;
    assign link_pass_out = pass_q;
    assign led_override_out = ovr_q;
    assign led_n_out = led_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_aui_sec_dis: assert property (cmd_in.valid && cmd_in.code == 8'h2E
        && is_secondary_in |=> !aui_enable_out && aui_part_idle_out)
        else $error("sec AUI disable");
    a_aui_pri_dis: assert property (cmd_in.valid && cmd_in.code == 8'h2F
        && !is_secondary_in |=> !aui_enable_out && aui_part_idle_out)
        else $error("pri AUI disable");
    a_aui_en_cmd: assert property (cmd_in.valid && cmd_in.code == 8'h3F
        && !is_secondary_in |=> aui_enable_out) else $error("pri AUI enable");
    a_aui_sec_en: assert property (cmd_in.valid && cmd_in.code == 8'h3E
        && is_secondary_in |=> aui_enable_out) else $error("sec AUI enable");
    a_aui_other: assert property (cmd_in.valid && cmd_in.code == 8'h2F
        && is_secondary_in |=> $stable(aui_enable_out))
        else $error("AUI command for other device");
    a_tp_dis_idle: assert property (cmd_in.valid
        && cmd_in.code == {5'h04, ~is_secondary_in, 2'h1}
        |=> !tp_cfg_out.enable[1] && tp_part_idle_out == 4'h2) else $error("port 1 disable");
    a_tp_en_port: assert property (cmd_in.valid
        && cmd_in.code == {5'h06, ~is_secondary_in, 2'h2}
        |=> tp_cfg_out.enable[2]) else $error("port 2 enable");
    a_tp_wrong_dev: assert property (cmd_in.valid && cmd_in.code[7:3] == 5'h06
        && cmd_in.code[2] == is_secondary_in |=> $stable(tp_cfg_out.enable))
        else $error("foreign port changed");
    a_link_pass: assert property (!tp_cfg_out.link_test_en[1] ##1
        !tp_cfg_out.link_test_en[1] |-> link_pass_out[1]) else $error("link pass not forced");
    a_link_test: assert property (cmd_in.valid && cmd_in.code[7:3] == 5'h08
        && cmd_in.code[2] != is_secondary_in
        |=> (tp_cfg_out.link_test_en & (4'h1 << $past(cmd_in.code[1:0]))) == 4'h0)
        else $error("link test off");
    a_link_test_on: assert property (cmd_in.valid && cmd_in.code[7:3] == 5'h0A
        && cmd_in.code[2] != is_secondary_in
        |=> (tp_cfg_out.link_test_en & (4'h1 << $past(cmd_in.code[1:0]))) != 4'h0)
        else $error("link test on");
    a_pulse_off: assert property (cmd_in.valid
        && cmd_in.code == {5'h09, ~is_secondary_in, 2'h3}
        |=> !tp_cfg_out.link_pulse_en[3]) else $error("link pulse off");
    a_pulse_on: assert property (cmd_in.valid
        && cmd_in.code == {5'h0B, ~is_secondary_in, 2'h3}
        |=> tp_cfg_out.link_pulse_en[3]) else $error("link pulse on");
    a_pol_off: assert property (cmd_in.valid
        && cmd_in.code == {5'h0C, ~is_secondary_in, 2'h0}
        |=> !tp_cfg_out.pol_auto_en[0]) else $error("polarity correction off");
    a_pol_on: assert property (cmd_in.valid
        && cmd_in.code == {5'h0E, ~is_secondary_in, 2'h0}
        |=> tp_cfg_out.pol_auto_en[0]) else $error("polarity correction on");
    a_ext_on: assert property (cmd_in.valid
        && cmd_in.code == {5'h0F, ~is_secondary_in, 2'h3}
        |=> tp_cfg_out.ext_dist[3]) else $error("extended distance on");
    a_ext_off: assert property (cmd_in.valid
        && cmd_in.code == {5'h0D, ~is_secondary_in, 2'h3}
        |=> !tp_cfg_out.ext_dist[3]) else $error("extended distance off");
    a_pol_strap: assert property ($fell(sys_rst_in)
        |-> tp_cfg_out.pol_auto_en == {4{~$past(serial_cmd_in)}}) else $error("polarity strap");
    a_led_all_on: assert property (cmd_in.valid && cmd_in.code == 8'hBC
        |=> led_override_out[4:0] == 5'h1F) else $error("override all ports");
    a_led_all_off: assert property (cmd_in.valid && cmd_in.code == 8'h9C
        |=> led_override_out[4:0] == 5'h00) else $error("override end all ports");
    a_led_solid: assert property (led_override_out[5] && blink_rate_in == 2'h3
        |=> !led_n_out[5]) else $error("override priority");
    a_led_dark: assert property (led_override_out[0] && blink_rate_in == 2'h0
        |=> led_n_out[0]) else $error("override at off rate");
    a_led_follow: assert property (!led_override_out[0]
        |=> led_n_out[0] == !$past(led_attr_in[0][led_display_config_inputs]))
        else $error("LED content from config");

    c_aui_cycle: cover property (!aui_enable_out ##[1:50] aui_enable_out);
    c_led_ovr: cover property (led_override_out != 6'h00 ##[1:50] led_override_out == 6'h00);
    c_tp_idle: cover property (tp_part_idle_out != 4'h0);
    c_link_forced: cover property (!tp_cfg_out.link_test_en[1] && link_pass_out[1]);
    c_blink_lit: cover property (led_override_out[5] && !led_n_out[5] ##1 led_n_out[5]);

endmodule : rpc_port_config

// [design/rpc_defines.svh]
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH

// ****************************************
// Command byte codes
// ****************************************
`define RPC_CMD_AUI_DIS_PRI 8'h2F
`define RPC_CMD_AUI_DIS_SEC 8'h2E
`define RPC_CMD_AUI_EN_PRI 8'h3F
`define RPC_CMD_AUI_EN_SEC 8'h3E
// Upper five bits of the per-port commands
`define RPC_OP_TP_DIS 5'h04
`define RPC_OP_TP_EN 5'h06
`define RPC_OP_LT_DIS 5'h08
`define RPC_OP_LT_EN 5'h0A
`define RPC_OP_LP_DIS 5'h09
`define RPC_OP_LP_EN 5'h0B
`define RPC_OP_POL_DIS 5'h0C
`define RPC_OP_POL_EN 5'h0E
`define RPC_OP_EXT_DIS 5'h0D
`define RPC_OP_EXT_EN 5'h0F
// Upper nibble of the LED override commands
`define RPC_OP_LED_OFF 4'h9
`define RPC_OP_LED_ON 4'hB

// ****************************************
// LED selector codes and LED indices
// ****************************************
`define RPC_SEL_AUI_PRI 4'h8
`define RPC_SEL_AUI_SEC 4'h9
`define RPC_SEL_AUI_ALL 4'hA
`define RPC_SEL_TP_ALL 4'hB
`define RPC_SEL_PORT_ALL 4'hC
`define RPC_SEL_GLB_PRI 4'hD
`define RPC_SEL_GLB_SEC 4'hE
`define RPC_SEL_GLB_ALL 4'hF
`define RPC_LED_AUI 4
`define RPC_LED_GLB 5

// ****************************************
// Reset values
// ****************************************
`define RPC_RST_TP_EN 4'hF
`define RPC_RST_LT_EN 4'hF
`define RPC_RST_LP_EN 4'hF
`define RPC_RST_EXT 4'h0
`define RPC_RST_OVR 6'h00

// ****************************************
// Blink timing
// ****************************************
`define RPC_CLK_KHZ 25000
`define RPC_BLINK_FAST_MS 512
`define RPC_BLINK_SLOW_MS 1560
`define RPC_BLINK_OFF 2'h0
`define RPC_BLINK_FAST 2'h1
`define RPC_BLINK_SLOW 2'h2
`define RPC_BLINK_SOLID 2'h3

`endif

// [design/rpc_pkg.sv]
package rpc_pkg;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } rpc_cmd_t;

    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] link_test_en;
        logic [3:0] link_pulse_en;
        logic [3:0] pol_auto_en;
        logic [3:0] ext_dist;
    } rpc_tp_cfg_t;

    typedef logic [5:0][7:0] rpc_led_attr_t;

endpackage : rpc_pkg

// [tb/rpc_mgmt_model.sv]
`timescale 1ns/1ps
// ****************************************
// Management controller on the serial port
// ****************************************
module rpc_mgmt_model (
    input wire logic clk_in,              // Device clock
    output rpc_pkg::rpc_cmd_t cmd_out,    // Command byte strobe
    output logic strap_out                // Serial line level
);
    initial begin
        cmd_out = '0;
        strap_out = 1'h0;
    end

    task automatic set_strap(input logic level);
        strap_out = level;
    endtask : set_strap

    // Released code shows the inverse byte, so a stale value is never mistaken for a command
    task automatic send_cmd(input logic [7:0] code);
        @(negedge clk_in);
        cmd_out = '{valid: 1'h1, code: code};
        @(negedge clk_in);
        cmd_out = '{valid: 1'h0, code: ~code};
    endtask : send_cmd
endmodule : rpc_mgmt_model

// [tb/tb_repeater_port_config_commands.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_repeater_port_config_commands;
    localparam int unsigned FAST_HALF = 4;
    localparam int unsigned SLOW_HALF = 6;
    localparam int MAX_CYCLES = 20000;
    logic clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic is_secondary_in = 1'h0;
    logic [3:0] link_raw_pass_in = 4'h5;
    logic [1:0] blink_rate_in = 2'h0;
    logic [2:0] led_display_config_inputs = 3'h2;
    rpc_pkg::rpc_led_attr_t led_attr_in = {6{8'h04}};
    rpc_pkg::rpc_cmd_t cmd;
    logic strap;
    logic aui_enable_out;
    logic aui_part_idle_out;
    rpc_pkg::rpc_tp_cfg_t tp_cfg_out;
    logic [3:0] tp_part_idle_out;
    logic [3:0] link_pass_out;
    logic [5:0] led_override_out;
    logic [5:0] led_n_out;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    int aui_pulses = 0;
    int tp_pulses = 0;
    logic [3:0] tp_seen = 4'h0;
    logic [19:0] exp_cfg;
    logic exp_aui;

    rpc_mgmt_model mgr_u (.clk_in(clk_in), .cmd_out(cmd), .strap_out(strap));

    rpc_port_config #(.BLINK_FAST_HALF(FAST_HALF), .BLINK_SLOW_HALF(SLOW_HALF)) dut_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .serial_cmd_in(strap),
        .is_secondary_in(is_secondary_in), .cmd_in(cmd), .link_raw_pass_in(link_raw_pass_in),
        .blink_rate_in(blink_rate_in), .led_display_config_inputs(led_display_config_inputs),
        .led_attr_in(led_attr_in), .aui_enable_out(aui_enable_out),
        .aui_part_idle_out(aui_part_idle_out), .tp_cfg_out(tp_cfg_out),
        .tp_part_idle_out(tp_part_idle_out), .link_pass_out(link_pass_out),
        .led_override_out(led_override_out), .led_n_out(led_n_out));

    // ****************************************
    // Clock, watchdog and pulse monitor
    // ****************************************
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == MAX_CYCLES) begin
            fails++;
            tally_and_finish();
        end
    end

    // Sampled mid-cycle so the pulse count never races the launching edge
    always @(negedge clk_in) begin
        if (aui_part_idle_out === 1'h1) aui_pulses++;
        if (!sys_rst_in) tp_pulses += $countones(tp_part_idle_out);
        if (!sys_rst_in) tp_seen |= tp_part_idle_out;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic cmd_byte(input logic [7:0] code);
        aui_pulses = 0;
        tp_pulses = 0;
        tp_seen = 4'h0;
        mgr_u.send_cmd(code);
        repeat (2) @(negedge clk_in);
    endtask : cmd_byte

    task automatic check_state();
        `CHK("tp_cfg", exp_cfg, tp_cfg_out)
        `CHK("aui_enable", exp_aui, aui_enable_out)
        `CHK("link_pass", link_raw_pass_in | ~exp_cfg[15:12], link_pass_out)
    endtask : check_state

    function automatic logic [5:0] sel_mask(input logic [3:0] sel, input logic sec);
        case (sel)
            4'h8: return sec ? 6'h00 : 6'h10;
            4'h9: return sec ? 6'h10 : 6'h00;
            4'hA: return 6'h10;
            4'hB: return 6'h0F;
            4'hC: return 6'h1F;
            4'hD: return sec ? 6'h00 : 6'h20;
            4'hE: return sec ? 6'h20 : 6'h00;
            4'hF: return 6'h20;
            default: return (sel[2] != sec) ? (6'h01 << sel[1:0]) : 6'h00;
        endcase
    endfunction : sel_mask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic do_reset(input logic level);
        sys_rst_in = 1'h1;
        mgr_u.set_strap(level);
        repeat (4) @(negedge clk_in);
        sys_rst_in = 1'h0;
        exp_cfg = {12'hFFF, {4{~level}}, 4'h0};
        exp_aui = 1'h1;
        repeat (2) @(negedge clk_in);
        check_state();
        `CHK("override_rst", 6'h00, led_override_out)
    endtask : do_reset

    task automatic test_aui();
        logic [7:0] own;
        for (int s = 0; s < 2; s++) begin
            is_secondary_in = s[0];
            own = s ? 8'h2E : 8'h2F;
            cmd_byte(own ^ 8'h01);
            check_state();
            `CHK("aui_idle_foreign", 0, aui_pulses)
            cmd_byte(own);
            exp_aui = 1'h0;
            check_state();
            `CHK("aui_idle", 1, aui_pulses)
            cmd_byte(own ^ 8'h11);
            check_state();
            cmd_byte(own ^ 8'h10);
            exp_aui = 1'h1;
            check_state();
        end
    endtask : test_aui

    task automatic test_ports();
        logic [4:0] off_op [5] = '{5'h04, 5'h08, 5'h09, 5'h0C, 5'h0D};
        logic [4:0] on_op [5] = '{5'h06, 5'h0A, 5'h0B, 5'h0E, 5'h0F};
        logic own;
        int idx;
        for (int s = 0; s < 2; s++) begin
            is_secondary_in = s[0];
            for (int f = 0; f < 5; f++) begin
                for (int p = 0; p < 8; p++) begin
                    own = (p[2] != s[0]);
                    idx = 16 - 4 * f + p[1:0];
                    cmd_byte({off_op[f], 3'(p)});
                    if (own) exp_cfg[idx] = 1'h0;
                    check_state();
                    if (f == 0) begin
                        `CHK("tp_idle", own ? (4'h1 << p[1:0]) : 4'h0, tp_seen)
                        `CHK("tp_idle_cnt", own ? 1 : 0, tp_pulses)
                    end
                    cmd_byte({on_op[f], 3'(p)});
                    if (own) exp_cfg[idx] = 1'h1;
                    check_state();
                end
            end
        end
    endtask : test_ports

    task automatic test_led_select();
        logic [5:0] m;
        for (int s = 0; s < 2; s++) begin
            is_secondary_in = s[0];
            for (int sel = 0; sel < 16; sel++) begin
                m = sel_mask(4'(sel), s[0]);
                cmd_byte({4'hB, 4'(sel)});
                `CHK("override_on", m, led_override_out)
                `CHK("led_on", m, led_n_out)
                cmd_byte({4'h9, 4'(sel)});
                `CHK("override_off", 6'h00, led_override_out)
                `CHK("led_off", 6'h00, led_n_out)
            end
        end
    endtask : test_led_select

    task automatic test_blink();
        int h;
        int lows;
        is_secondary_in = 1'h1;
        for (int r = 1; r < 4; r++) begin
            blink_rate_in = 2'(r);
            h = (r == 2) ? SLOW_HALF : FAST_HALF;
            lows = 0;
            cmd_byte(8'hBF);
            repeat (4 * h) begin
                @(negedge clk_in);
                if (led_n_out[5] === 1'h0) lows++;
            end
            `CHK("blink_lows", (r == 3) ? 4 * h : 2 * h, lows)
            cmd_byte(8'h9F);
        end
    endtask : test_blink

    initial begin
        do_reset(1'h0);
        do_reset(1'h1);
        test_aui();
        test_ports();
        test_led_select();
        test_blink();
        tally_and_finish();
    end
endmodule : tb_repeater_port_config_commands
